// ### bds_baud_gen.sv
// Data clock generator: toggles every half_i core clocks.
// Assumes half_i is at least one and restart_i is a one-cycle pulse.
`timescale 1ns/1ns
module bds_baud_gen
    import bds_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic restart_i,
    input wire logic [14:0] half_i,
    output logic level_o,
    output logic rise_o
);

    logic [14:0] cnt;
    logic [14:0] next_cnt;
    logic next_level;
    logic next_rise;

    always_comb begin
        next_cnt = cnt - 15'h1;
        next_level = level_o;
        next_rise = 1'b0;
        if (restart_i) begin
            // Restart from a full half period so no short pulse escapes
            next_cnt = half_i - 15'h1;
            next_level = 1'b0;
        end else if (cnt == 15'h0) begin
            next_cnt = half_i - 15'h1;
            next_level = ~level_o;
            next_rise = ~level_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cnt <= 15'h0;
            level_o <= 1'b0;
            rise_o <= 1'b0;
        end else begin
            cnt <= next_cnt;
            level_o <= next_level;
            rise_o <= next_rise;
        end
    end

endmodule

// ### bds_pkg.sv
// Package for the baud divider and synthesizer word select block.
// Assumes a single 10 MHz core clock and an AXI4-Lite register master.
package bds_pkg;

    // ------------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CLOCK = 8'h00;
    localparam logic [7:0] OFS_WORD_A = 8'h04;
    localparam logic [7:0] OFS_WORD_B = 8'h08;
    localparam logic [7:0] OFS_CONTROL = 8'h0c;
    localparam logic [7:0] OFS_DEVIATION = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    localparam int CLK_REF_LSB = 0;
    localparam int CLK_CODE_A_LSB = 4;
    localparam int CLK_CODE_B_LSB = 8;
    localparam int CTL_SELECT_BIT = 0;
    localparam int CTL_BAND_BIT = 1;
    localparam int CTL_ASYNC_BIT = 2;
    localparam int DEV_MANT_LSB = 0;
    localparam int DEV_EXP_LSB = 4;
    localparam int DEV_SHAPE_BIT = 7;
    localparam int WORD_WIDTH = 24;

    localparam logic [2:0] REF_DIV_RST = 3'h1;
    localparam logic [23:0] WORD_RST = 24'h000000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // Divider and synthesizer constants
    // ------------------------------------------------------------------
    // Half of the fixed pre-divide of eight; the chain toggles per half
    localparam logic [2:0] PRE_HALF = 3'h4;
    // Ratios are scaled by two to the RATIO_FRAC_BITS
    localparam int RATIO_FRAC_BITS = 16;
    localparam logic [25:0] RATIO_LOW_BASE = 26'h000c000;
    localparam logic [25:0] RATIO_HIGH_BASE = 26'h0018000;
    localparam int DEV_OFS_LOW = 16;
    localparam int DEV_OFS_HIGH = 15;

    typedef struct packed {
        logic [1:0] master_divide_code_b;
        logic [2:0] master_divide_code_a;
        logic [2:0] ref_div;
    } bds_clock_t;

    typedef struct packed {
        logic async_mode;
        logic band_choice;
        logic word_select;
    } bds_ctl_t;

    typedef struct packed {
        logic shaping;
        logic [2:0] deviation_exponent;
        logic [3:0] deviation_mantissa;
    } bds_dev_t;

    // Four times the first master factor, so that 2.5 etc. stay integer
    function automatic logic [8:0] master_factor_a_x4(input logic [2:0] c);
        case (c)
            3'h0: master_factor_a_x4 = 9'h00a;
            3'h1: master_factor_a_x4 = 9'h00c;
            3'h2: master_factor_a_x4 = 9'h010;
            3'h3: master_factor_a_x4 = 9'h01e;
            3'h4: master_factor_a_x4 = 9'h032;
            3'h5: master_factor_a_x4 = 9'h0a0;
            3'h6: master_factor_a_x4 = 9'h0c0;
            default: master_factor_a_x4 = 9'h100;
        endcase
    endfunction

    function automatic logic [3:0] master_factor_b(input logic [1:0] c);
        master_factor_b = 4'h1 << c;
    endfunction

endpackage

// ### bds_top.sv
// Baud divider, synthesizer word select and modulation control.
// Assumes an AXI4-Lite master on the core clock and TX data in sync.
//
// Notes on behaviour
// R1: Data clock is crystal over eight, reference divide plus one, both factors.
// R2: Second master code 00..11 gives factors 1, 2, 4, 8.
// R3: First master code 000..111 gives 2.5,3,4,7.5,12.5,40,48,64.
// R4: Async transparent mode passes transmit data at any rate, ignoring dividers.
// R5: Two synthesizer words; one control bit picks the active word.
// R6: Each word is three bytes; low byte bit zero is flag_a flag.
// R7: Low band output is reference times (3/4 + (word+flag_a/2)/32768).
// R8: High band output is reference times (3/2 + (word+flag_a/2)/16384).
// R9: Band bit clear selects 402-470 MHz, set selects 804-930 MHz.
// R10: Reference equals crystal over one plus three-bit reference divide.
// R11: Software picks smallest reference divide meeting the reference limits.
// R12: Deviation is a four-bit mantissa and three-bit exponent.
// R13: Deviation is reference times mantissa times 2^(exp-16) or 2^(exp-15).
// R14: FSK sends carrier minus deviation for zero, plus for one.
// R15: All-zero mantissa selects on-off keying instead of FSK.
// R16: Shaping bit enables Gaussian shaping of the modulating signal.
// R17: Software programs receive word to carrier minus the IF.
// R18: Flag_a flag in low byte activates divider dithering.
// R19: Divider restarts cleanly whenever a divide field or band changes.
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
module bds_top
    import bds_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic RESET_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [7:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    output logic [1:0] S_AXI_BRESP_O,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    input wire logic [7:0] S_AXI_ARADDR_I,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    input wire logic TX_DATA_I,
    output logic DATA_CLK_O,
    output logic [25:0] CARRIER_RATIO_O,
    output logic [25:0] TONE_RATIO_O,
    output logic RF_ON_O,
    output logic OOK_MODE_O,
    output logic GAUSS_EN_O,
    output logic FLAG_A_O,
    output logic BAND_O,
    output logic [3:0] REF_DIVISOR_O
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        if (a == OFS_CLOCK) mapped = 1'b1;
        else if (a == OFS_WORD_A) mapped = 1'b1;
        else if (a == OFS_WORD_B) mapped = 1'b1;
        else if (a == OFS_CONTROL) mapped = 1'b1;
        else if (a == OFS_DEVIATION) mapped = 1'b1;
        else if (a == OFS_STATUS) mapped = 1'b1;
        else mapped = 1'b0;
    endfunction

    // Word holds 23 frequency bits over the flag_a flag, so 2W+D = word
    function automatic logic [25:0] carrier_ratio(input logic band,
                                                  input logic [23:0] w);
        if (band) carrier_ratio = RATIO_HIGH_BASE + {1'b0, w, 1'b0};
        else carrier_ratio = RATIO_LOW_BASE + {2'b00, w};
    endfunction

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    bds_clock_t clk_cfg, next_clk_cfg;
    bds_ctl_t ctl, next_ctl;
    bds_dev_t dev, next_dev;
    logic [23:0] synth_word_a, next_synth_word_a;
    logic [23:0] synth_word_b, next_synth_word_b;
    logic aw_held, next_aw_held, w_held, next_w_held;
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata, wr_word, clk_word, ctl_word, dev_word, rd_word;
    logic do_write, symbol, next_symbol;
    bds_clock_t last_clk_cfg;
    logic last_band, restart, rise;
    logic [14:0] half;
    logic [16:0] half_x4;
    logic [23:0] sel_word;
    logic [25:0] carrier, deviation, next_tone;
    logic [4:0] dev_shift;

    assign clk_word = {22'h0, clk_cfg.master_divide_code_b, 1'b0,
                       clk_cfg.master_divide_code_a, 1'b0, clk_cfg.ref_div};
    assign ctl_word = {29'h0, ctl};
    assign dev_word = {24'h0, dev};
    assign do_write = aw_held && w_held && !S_AXI_BVALID_O;
    assign wr_word = merge(rd_word, w_data, w_strb);

    always_comb begin
        if (aw_addr == OFS_CLOCK) rd_word = clk_word;
        else if (aw_addr == OFS_WORD_A) rd_word = {8'h0, synth_word_a};
        else if (aw_addr == OFS_WORD_B) rd_word = {8'h0, synth_word_b};
        else if (aw_addr == OFS_CONTROL) rd_word = ctl_word;
        else if (aw_addr == OFS_DEVIATION) rd_word = dev_word;
        else rd_word = 32'h0;
    end

    // ------------------------------------------------------------------
    // Write channel and configuration
    // ------------------------------------------------------------------
    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = S_AXI_BVALID_O;
        next_bresp = S_AXI_BRESP_O;
        next_clk_cfg = clk_cfg;
        next_ctl = ctl;
        next_dev = dev;
        next_synth_word_a = synth_word_a;
        next_synth_word_b = synth_word_b;
        if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
            next_aw_held = 1'b1;
            next_aw_addr = S_AXI_AWADDR_I;
        end
        if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
            next_w_held = 1'b1;
            next_w_data = S_AXI_WDATA_I;
            next_w_strb = S_AXI_WSTRB_I;
        end
        if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
            next_bvalid = 1'b0;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            // Status is read-only: a write there is accepted and dropped
            next_bresp = mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
            if (aw_addr == OFS_CLOCK) begin
                next_clk_cfg.ref_div = wr_word[CLK_REF_LSB +: 3];
                next_clk_cfg.master_divide_code_a =
                    wr_word[CLK_CODE_A_LSB +: 3];
                next_clk_cfg.master_divide_code_b =
                    wr_word[CLK_CODE_B_LSB +: 2];
            end else if (aw_addr == OFS_WORD_A) begin
                // R6 three bytes
                next_synth_word_a = wr_word[WORD_WIDTH-1:0];
            end else if (aw_addr == OFS_WORD_B) begin
                next_synth_word_b = wr_word[WORD_WIDTH-1:0];
            end else if (aw_addr == OFS_CONTROL) begin
                next_ctl.word_select = wr_word[CTL_SELECT_BIT];
                next_ctl.band_choice = wr_word[CTL_BAND_BIT];
                next_ctl.async_mode = wr_word[CTL_ASYNC_BIT];
            end else if (aw_addr == OFS_DEVIATION) begin
                // R12 mantissa exponent
                next_dev.deviation_mantissa = wr_word[DEV_MANT_LSB +: 4];
                next_dev.deviation_exponent = wr_word[DEV_EXP_LSB +: 3];
                next_dev.shaping = wr_word[DEV_SHAPE_BIT];
            end
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h0;
            w_held <= 1'b0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            S_AXI_AWREADY_O <= 1'b0;
            S_AXI_WREADY_O <= 1'b0;
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O <= RESP_OKAY;
            clk_cfg <= '{master_divide_code_b: 2'h0,
                         master_divide_code_a: 3'h0, ref_div: REF_DIV_RST};
            ctl <= '0;
            dev <= '0;
            synth_word_a <= WORD_RST;
            synth_word_b <= WORD_RST;
        end else begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            S_AXI_AWREADY_O <= next_awready;
            S_AXI_WREADY_O <= next_wready;
            S_AXI_BVALID_O <= next_bvalid;
            S_AXI_BRESP_O <= next_bresp;
            clk_cfg <= next_clk_cfg;
            ctl <= next_ctl;
            dev <= next_dev;
            synth_word_a <= next_synth_word_a;
            synth_word_b <= next_synth_word_b;
        end
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    always_comb begin
        next_rvalid = S_AXI_RVALID_O;
        next_rdata = S_AXI_RDATA_O;
        next_rresp = S_AXI_RRESP_O;
        if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
            next_rvalid = 1'b0;
        end
        if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
            next_rvalid = 1'b1;
            next_rresp = mapped(S_AXI_ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
            if (S_AXI_ARADDR_I == OFS_CLOCK) next_rdata = clk_word;
            else if (S_AXI_ARADDR_I == OFS_WORD_A) begin
                next_rdata = {8'h0, synth_word_a};
            end else if (S_AXI_ARADDR_I == OFS_WORD_B) begin
                next_rdata = {8'h0, synth_word_b};
            end else if (S_AXI_ARADDR_I == OFS_CONTROL) next_rdata = ctl_word;
            else if (S_AXI_ARADDR_I == OFS_DEVIATION) next_rdata = dev_word;
            else if (S_AXI_ARADDR_I == OFS_STATUS) begin
                next_rdata = {28'h0, FLAG_A_O, OOK_MODE_O, symbol, DATA_CLK_O};
            end else next_rdata = 32'h0;
        end
        next_arready = !next_rvalid;
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O <= 32'h0;
            S_AXI_RRESP_O <= RESP_OKAY;
        end else begin
            S_AXI_ARREADY_O <= next_arready;
            S_AXI_RVALID_O <= next_rvalid;
            S_AXI_RDATA_O <= next_rdata;
            S_AXI_RRESP_O <= next_rresp;
        end
    end

    // ------------------------------------------------------------------
    // Data clock chain
    // ------------------------------------------------------------------
    // R1 R2 R3 divide chain
    // Factor a is kept times four, so the product drops two bits (max 16384)
    assign half_x4 = 17'(({14'h0, clk_cfg.ref_div} + 17'h1) * PRE_HALF *
                         master_factor_a_x4(clk_cfg.master_divide_code_a) *
                         master_factor_b(clk_cfg.master_divide_code_b));
    assign half = half_x4[16:2];
    // R19 restart on change
    assign restart = (last_clk_cfg != clk_cfg) || (last_band != BAND_O);

    bds_baud_gen u_baud_gen (
        .clk_i(CORE_CLK_I),
        .reset_i(RESET_I),
        .restart_i(restart),
        .half_i(half),
        .level_o(DATA_CLK_O),
        .rise_o(rise)
    );

    // ------------------------------------------------------------------
    // Synthesizer and modulation
    // ------------------------------------------------------------------
    // R5 word select
    assign sel_word = ctl.word_select ? synth_word_b : synth_word_a;
    // R7 R8 R9 band ratio
    assign carrier = carrier_ratio(ctl.band_choice, sel_word);
    // R13 exponent offset per band
    assign dev_shift = 5'(dev.deviation_exponent) +
        5'(RATIO_FRAC_BITS) -
        (ctl.band_choice ? 5'(DEV_OFS_HIGH) : 5'(DEV_OFS_LOW));
    assign deviation = {22'h0, dev.deviation_mantissa} << dev_shift;

    always_comb begin
        next_symbol = symbol;
        // R4 async bypass
        if (ctl.async_mode) next_symbol = TX_DATA_I;
        else if (rise) next_symbol = TX_DATA_I;
        // R14 FSK tones
        next_tone = symbol ? carrier + deviation : carrier - deviation;
        // R15 OOK keeps carrier
        if (dev.deviation_mantissa == 4'h0) next_tone = carrier;
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            symbol <= 1'b0;
            last_clk_cfg <= '0;
            last_band <= 1'b0;
            CARRIER_RATIO_O <= RATIO_LOW_BASE;
            TONE_RATIO_O <= RATIO_LOW_BASE;
            RF_ON_O <= 1'b0;
            OOK_MODE_O <= 1'b1;
            GAUSS_EN_O <= 1'b0;
            FLAG_A_O <= 1'b0;
            BAND_O <= 1'b0;
            REF_DIVISOR_O <= 4'h1;
        end else begin
            symbol <= next_symbol;
            last_clk_cfg <= clk_cfg;
            last_band <= BAND_O;
            CARRIER_RATIO_O <= carrier;
            TONE_RATIO_O <= next_tone;
            // R15 carrier keyed by data
            RF_ON_O <= (dev.deviation_mantissa != 4'h0) || symbol;
            OOK_MODE_O <= dev.deviation_mantissa == 4'h0;
            // R16 shaping enable
            GAUSS_EN_O <= dev.shaping;
            // R18 flag_a from active word
            FLAG_A_O <= sel_word[0];
            BAND_O <= ctl.band_choice;
            // R10 reference divisor
            REF_DIVISOR_O <= {1'b0, clk_cfg.ref_div} + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    logic [15:0] gap;
    logic gap_ok;
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I || restart) begin
            gap <= 16'h0;
            gap_ok <= 1'b0;
        end else if (rise) begin
            gap <= 16'h0;
            gap_ok <= 1'b1;
        end else begin
            gap <= gap + 16'h1;
        end
    end

    property p_period;
        @(posedge CORE_CLK_I) disable iff (RESET_I)
        rise && gap_ok && !restart |-> gap == {half, 1'b0} - 16'h1;
    endproperty
    a_period: assert property (p_period) else $error("period wrong"); // R1
    property p_code_b;
        @(posedge CORE_CLK_I) disable iff (RESET_I)
        clk_cfg == bds_clock_t'{2'h2, 3'h2, 3'h0} |-> half == 15'h0040;
    endproperty
    a_code_b: assert property (p_code_b) else $error("code b wrong"); // R2
    property p_code_a;
        @(posedge CORE_CLK_I) disable iff (RESET_I)
        clk_cfg == bds_clock_t'{2'h0, 3'h0, 3'h0} |-> half == 15'h000a;
    endproperty
    a_code_a: assert property (p_code_a) else $error("code a wrong"); // R3
    property p_async;
        @(posedge CORE_CLK_I) disable iff (RESET_I)
        ctl.async_mode |=> symbol == $past(TX_DATA_I);
    endproperty
    a_async: assert property (p_async) else $error("async lag"); // R4
    property p_low_a;
        @(posedge CORE_CLK_I) disable iff (RESET_I)
        !ctl.band_choice && !ctl.word_select |=>
            CARRIER_RATIO_O == RATIO_LOW_BASE + {2'h0, $past(synth_word_a)};
    endproperty
    a_low_a: assert property (p_low_a) else $error("low carrier"); // R7
    property p_high_b;
        @(posedge CORE_CLK_I) disable iff (RESET_I)
        ctl.band_choice && ctl.word_select |=> CARRIER_RATIO_O ==
            RATIO_HIGH_BASE + {1'b0, $past(synth_word_b), 1'b0};
    endproperty
    a_high_b: assert property (p_high_b) else $error("high carrier"); // R8
    property p_flag_a;
        @(posedge CORE_CLK_I) disable iff (RESET_I)
        ctl.word_select |=> FLAG_A_O == $past(synth_word_b[0]);
    endproperty
    a_flag_a: assert property (p_flag_a) else $error("flag_a flag"); // R18
    property p_fsk_low;
        @(posedge CORE_CLK_I) disable iff (RESET_I)
        dev == bds_dev_t'{1'b0, 3'h0, 4'h1} && !ctl.band_choice && !symbol |=>
            TONE_RATIO_O == $past(carrier) - 26'h1;
    endproperty
    a_fsk_low: assert property (p_fsk_low) else $error("fsk tone"); // R14
    property p_ook;
        @(posedge CORE_CLK_I) disable iff (RESET_I)
        dev.deviation_mantissa == 4'h0 |=>
            OOK_MODE_O && TONE_RATIO_O == $past(carrier)
            && RF_ON_O == $past(symbol);
    endproperty
    a_ook: assert property (p_ook) else $error("ook mode"); // R15
    property p_restart;
        @(posedge CORE_CLK_I) disable iff (RESET_I)
        restart |=> !DATA_CLK_O && !rise;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart"); // R19

    c_write: cover property (@(posedge CORE_CLK_I) S_AXI_BVALID_O
        && S_AXI_BREADY_I);
    c_read: cover property (@(posedge CORE_CLK_I) S_AXI_RVALID_O
        && S_AXI_RREADY_I);
    c_rise: cover property (@(posedge CORE_CLK_I) rise && gap_ok);
    c_ook: cover property (@(posedge CORE_CLK_I) OOK_MODE_O && RF_ON_O);

endmodule

// ### bds_top_tb.sv
// Testbench for bds_top: AXI4-Lite register tasks and port checks.
// Assumes the register map and ratio scaling of bds_pkg.
`timescale 1ns/1ns
module bds_top_tb;
    import bds_pkg::*;
    logic clk = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, txd = 0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rd, q;
    logic [1:0] rp;
    logic aw_rdy, w_rdy, bv, ar_rdy, rv, dclk, rf_on, ook, gs, dth, band;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [25:0] car, tone;
    logic [3:0] refd;
    int err_total = 0, n_checks = 0, cyc = 0, p;
    always #50 clk = ~clk;
    bds_top DUT (.CORE_CLK_I(clk), .RESET_I(rst), .S_AXI_AWVALID_I(awv),
        .S_AXI_AWREADY_O(aw_rdy), .S_AXI_AWADDR_I(awa), .S_AXI_WVALID_I(wv),
        .S_AXI_WREADY_O(w_rdy), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf),
        .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br), .S_AXI_BRESP_O(bresp),
        .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(ar_rdy),
        .S_AXI_ARADDR_I(ara), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .TX_DATA_I(txd),
        .DATA_CLK_O(dclk), .CARRIER_RATIO_O(car), .TONE_RATIO_O(tone),
        .RF_ON_O(rf_on), .OOK_MODE_O(ook), .GAUSS_EN_O(gs),
        .FLAG_A_O(dth), .BAND_O(band), .REF_DIVISOR_O(refd));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit ad, wdn, bd;
        ad = 0; wdn = 0; bd = 0;
        @(posedge clk);
        awv <= 1; awa <= a; wv <= 1; wd <= d; br <= 1;
        while (!bd) begin
            @(posedge clk);
            if (!ad && aw_rdy === 1'b1) begin ad = 1; awv <= 0; end
            if (!wdn && w_rdy === 1'b1) begin wdn = 1; wv <= 0; end
            if (bv === 1'b1) begin bd = 1; br <= 0; rp = bresp; end
        end
        repeat (3) @(posedge clk);
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        bit ad, dn;
        ad = 0; dn = 0;
        @(posedge clk);
        arv <= 1; ara <= a; rr <= 1;
        while (!dn) begin
            @(posedge clk);
            if (!ad && ar_rdy === 1'b1) begin ad = 1; arv <= 0; end
            if (rv === 1'b1) begin dn = 1; rr <= 0; d = rdata; rp = rresp; end
        end
    endtask
    // Rising edge to rising edge of the data clock, in core cycles
    task automatic per(output int n);
        while (dclk !== 1'b0) @(posedge clk);
        while (dclk !== 1'b1) @(posedge clk);
        n = 0;
        while (dclk !== 1'b0) begin @(posedge clk); n++; end
        while (dclk !== 1'b1) begin @(posedge clk); n++; end
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin err_total++; tally_and_finish(); end
    end
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        logic [11:0] codes [5] = '{12'h000, 12'h100, 12'h220, 12'h010,
                                   12'h001};
        int pers [5] = '{20, 40, 128, 24, 40};
        repeat (16) @(posedge clk);
        rst <= 0;
        repeat (2) @(posedge clk);
        chk(32'(car), 32'h000c000); // low band base
        chk(32'(refd), 32'h2); // reset divide
        chk(32'(ook), 32'h1); // zero mantissa
        rd_reg(OFS_CLOCK, q);
        chk(q, 32'h1);
        for (int i = 0; i < 5; i++) begin
            wr(OFS_CLOCK, 32'(codes[i]));
            per(p);
            chk(32'(p), 32'(pers[i]));
        end
        chk(32'(refd), 32'h2);
        wr(OFS_WORD_A, 32'h000101);
        rd_reg(OFS_WORD_A, q);
        chk(q, 32'h000101);
        chk(32'(car), 32'h000c101);
        chk(32'(dth), 32'h1);
        wr(OFS_WORD_B, 32'h000200);
        wr(OFS_CONTROL, 32'h1);
        chk(32'(car), 32'h000c200);
        chk(32'(dth), 32'h0);
        wr(OFS_CONTROL, 32'h7);
        chk(32'(car), 32'h0018400);
        chk(32'(band), 32'h1);
        wr(OFS_DEVIATION, 32'h0a3);
        chk(32'(ook), 32'h0);
        chk(32'(gs), 32'h1);
        txd <= 1;
        repeat (4) @(posedge clk);
        chk(32'(tone), 32'h0018418);
        txd <= 0;
        repeat (4) @(posedge clk);
        chk(32'(tone), 32'h00183e8);
        wr(OFS_DEVIATION, 32'h0);
        chk(32'(rf_on), 32'h0);
        wr(OFS_CONTROL, 32'h4);
        wr(OFS_DEVIATION, 32'h1);
        chk(32'(tone), 32'h000c100);
        chk(32'(rf_on), 32'h1);
        rd_reg(8'h18, q);
        chk(32'(rp), 32'(RESP_SLVERR));
        wr(8'h18, 32'h5);
        chk(32'(rp), 32'(RESP_SLVERR));
        tally_and_finish();
    end
endmodule
